// >>> verilog/servo_port_pkg.sv
// Purpose: shared constants for the servo port pin control block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: byte address of a register is four times its index
package servo_port_pkg;

    // ****************************************************************
    // register indices and decode
    // ****************************************************************
    localparam logic [2:0] IDX_PIN_MODE = 3'h0; // servo_pin_mode_reg
    localparam logic [2:0] IDX_GPIO_DIR = 3'h1; // servo_gpio_direction
    localparam logic [2:0] IDX_GPIO_DATA = 3'h2; // servo_gpio_data
    localparam logic [2:0] IDX_MON_SEL = 3'h3; // servo_monitor_select
    localparam logic [2:0] IDX_AMP_CTL = 3'h4; // track_amp_control
    localparam int REG_COUNT = 5;
    localparam int ADDR_WIDTH = 12;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0] PIN_MODE_RESET = 8'h40;
    localparam logic [7:0] GPIO_DIR_RESET = 8'he0;
    localparam logic [7:0] GPIO_DATA_RESET = 8'he0;
    localparam logic [7:0] MON_SEL_RESET = 8'hc0;
    localparam logic [7:0] AMP_CTL_RESET = 8'hc0;
    localparam logic [7:0] WO_READ_VALUE = 8'hff; // undefined read of write-only reg

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int MODE_TRACK_STOP = 7;
    localparam int MODE_CAP_DIGITAL = 5;
    localparam int MODE_EXT_TRACK = 4; // ext_track_pin_release
    localparam int MODE_DRUM_OVERLAP = 3; // drum_input_overlap_sel
    localparam int MODE_COMPARE = 2;
    localparam int MODE_HEAD_AMP = 1; // head_amp_select_release
    localparam int MODE_COLOR_ROT = 0;
    localparam int GPIO_WIDTH = 5;
    localparam int MON_B_LSB = 3;
    localparam int MON_A_LSB = 0;
    localparam int AMP_SRC_SEL = 5; // track_pulse_source_sel
    localparam int AMP_FEEDBACK = 4; // amp_feedback_switch
    localparam int AMP_GAIN_LSB = 0; // amp_gain_code, four bits

    // ****************************************************************
    // monitor source codes and gain table
    // ****************************************************************
    typedef enum logic [2:0] {
        MON_PRIMARY_REF, MON_ALT_CAP_REF, MON_CAP_REF, MON_TRACK_MON,
        MON_DIV_CAP_TACH, MON_CAP_TACH, MON_DRUM_TACH, MON_DRUM_PHASE
    } mon_src_t;
    localparam logic [9:0] GAIN_BASE_TENTH_DB = 10'h154; // 34.0 dB at code 0
    localparam logic [9:0] GAIN_STEP_TENTH_DB = 10'h019; // 2.5 dB per code step

endpackage

// >>> verilog/servo_monitor_mux.sv
// Purpose: one monitor output, picks one of eight servo signals
// Assumes: pinSel high while the shared pin is set up as monitor output
// Notes: output and enable are registered
`timescale 1ns/10ps
module servo_monitor_mux
    import servo_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [2:0] sel,
    input wire logic [7:0] sources,
    input wire logic pinSel,
    output logic monOut,
    output logic monOe
);

    // ****************************************************************
    // selection register
    // ****************************************************************
    // idle low when the pin belongs to the general-purpose port
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            monOut <= 1'b0;
            monOe <= 1'b0;
        end else begin
            monOut <= pinSel ? sources[sel] : 1'b0;
            monOe <= pinSel;
        end
    end

    chk_mon_route: assert property (@(posedge clk_sys) disable iff (rst)
        pinSel |=> monOe && monOut == $past(sources[sel]))
        else $error("monitor output does not follow selected source");
    chk_mon_release: assert property (@(posedge clk_sys) disable iff (rst)
        !pinSel |=> !monOe && !monOut)
        else $error("monitor drives pin while not selected");

endmodule

// >>> verilog/servo_gpio_cell.sv
// Purpose: one dual-purpose servo pin, servo function or general port
// Assumes: pin input synchronous to clk_sys
// Notes: pin drive and servo-side value are registered
`timescale 1ns/10ps
module servo_gpio_cell (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic gpioMode,
    input wire logic dirBit,
    input wire logic dataBit,
    input wire logic servoIsOutput,
    input wire logic servoDrive,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic toServo,
    output logic readBit
);

    // ****************************************************************
    // pin drive
    // ****************************************************************
    // direction and latch count only in general-purpose mode
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinOut <= 1'b0;
            pinOe <= 1'b0;
            toServo <= 1'b0;
        end else if (gpioMode) begin
            pinOut <= dataBit;
            pinOe <= dirBit;
            toServo <= 1'b0;
        end else begin
            pinOut <= servoIsOutput ? servoDrive : 1'b0;
            pinOe <= servoIsOutput;
            toServo <= servoIsOutput ? 1'b0 : pinIn;
        end
    end

    // output bit reads the latch, input bit reads the pin
    assign readBit = dirBit ? dataBit : pinIn;

endmodule

// >>> verilog/servo_port_pin_control.sv
// Purpose: servo port pin control: pin modes, general port, monitor mux, amp control
// Assumes: apb slave, zero wait states, standby resets like rst
// Notes: register changes reach the pins one clock after the write edge
`timescale 1ns/10ps
module servo_port_pin_control
    import servo_port_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic standby,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [4:0] servoGpioPinsIn,
    output logic [4:0] servoGpioPinsOut,
    output logic [4:0] servoGpioPinsOe,
    input wire logic colorRotaryDrive,
    input wire logic headAmpSelectDrive,
    output logic preampCompareResult,
    input wire logic drumTachSignal,
    output logic drumPhasePulse,
    output logic drumInputsOverlapped,
    output logic externalTrackPulseInput,
    input wire logic ampOutputPulse,
    output logic trackPulseToCircuit,
    input wire logic primaryReferenceSignal,
    input wire logic alternateCapstanReference,
    input wire logic capstanReferenceSignal,
    input wire logic trackMonitorSignal,
    input wire logic dividedCapstanTach,
    input wire logic capstanTachSignal,
    input wire logic monitorPinSelA,
    input wire logic monitorPinSelB,
    output logic monitorOutA,
    output logic monitorOeA,
    output logic monitorOutB,
    output logic monitorOeB,
    output logic trackCircuitStop,
    output logic capstanTachDigital,
    output logic ampFeedbackSwitch,
    output logic [3:0] ampGainCode,
    output logic [9:0] ampGainTenthDb
);

    // ****************************************************************
    // register state
    // ****************************************************************
    logic resetAll; // reset or standby entry
    logic [7:0] pinMode_r; // servo_pin_mode_reg
    logic [4:0] gpioDir_r; // servo_gpio_direction, low five bits
    logic [4:0] gpioData_r; // servo_gpio_data latch
    logic [5:0] monSel_r; // servo_monitor_select
    logic [5:0] ampCtl_r; // track_amp_control
    logic [4:0] gpioRead; // per-pin readback value
    logic [4:0] fromPins; // servo inputs taken from the shared pins
    logic [4:0] servoIsOut; // which servo functions drive their pin
    logic [4:0] servoDrive; // values driven in servo mode
    logic [7:0] monSources; // eight monitor candidates
    logic apbSetup; // first cycle of a transfer
    logic apbWrite; // access cycle of a write
    logic [7:0] readValue; // byte returned for current address
    logic [7:0] readValue_nxt;
    logic [31:0] prdata_r;
    logic pslverr_r;

    assign resetAll = rst | standby;

    // ****************************************************************
    // address decode
    // ****************************************************************
    // word index, valid only for aligned addresses
    function automatic logic [2:0] reg_index(input logic [11:0] addr);
        reg_index = addr[4:2];
    endfunction

    // true when the address hits one of the five registers
    function automatic logic reg_hit(input logic [11:0] addr);
        reg_hit = (addr[1:0] == 2'h0) && (addr[11:5] == 7'h00) &&
            (int'(addr[4:2]) < REG_COUNT);
    endfunction

    // gain in tenths of a dB for a four-bit code
    function automatic logic [9:0] gain_tenth_db(input logic [3:0] code);
        gain_tenth_db = GAIN_BASE_TENTH_DB + GAIN_STEP_TENTH_DB * {6'h00, code};
    endfunction

    // ****************************************************************
    // apb handshake
    // ****************************************************************
    // zero wait: every access phase completes at once
    assign pready = 1'b1;
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite & pslverr_r == 1'b0;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r & psel & penable;

    // ****************************************************************
    // register writes
    // ****************************************************************
    // pin mode; bit6 reserved, always reads one
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            pinMode_r <= PIN_MODE_RESET;
        end else if (apbWrite && reg_index(paddr) == IDX_PIN_MODE) begin
            pinMode_r <= {pwdata[7], 1'b1, pwdata[5:0]};
        end
    end

    // direction; reserved bits 7..5 are not stored
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            gpioDir_r <= GPIO_DIR_RESET[4:0];
        end else if (apbWrite && reg_index(paddr) == IDX_GPIO_DIR) begin
            gpioDir_r <= pwdata[4:0];
        end
    end

    // data latch, written whatever the direction
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            gpioData_r <= GPIO_DATA_RESET[4:0];
        end else if (apbWrite && reg_index(paddr) == IDX_GPIO_DATA) begin
            gpioData_r <= pwdata[4:0];
        end
    end

    // monitor select
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            monSel_r <= MON_SEL_RESET[5:0];
        end else if (apbWrite && reg_index(paddr) == IDX_MON_SEL) begin
            monSel_r <= pwdata[5:0];
        end
    end

    // amplifier control
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            ampCtl_r <= AMP_CTL_RESET[5:0];
        end else if (apbWrite && reg_index(paddr) == IDX_AMP_CTL) begin
            ampCtl_r <= pwdata[5:0];
        end
    end

    // ****************************************************************
    // register reads
    // ****************************************************************
    // reserved bits read as ones; write-only register reads ff
    always_comb begin
        readValue_nxt = 8'h00;
        unique case (reg_index(paddr))
            IDX_PIN_MODE: readValue_nxt = pinMode_r;
            IDX_GPIO_DIR: readValue_nxt = WO_READ_VALUE;
            IDX_GPIO_DATA: readValue_nxt = {3'h7, gpioRead};
            IDX_MON_SEL: readValue_nxt = {2'h3, monSel_r};
            IDX_AMP_CTL: readValue_nxt = {2'h3, ampCtl_r};
            default: readValue_nxt = 8'h00; // unmapped index
        endcase
        readValue = reg_hit(paddr) ? readValue_nxt : 8'h00;
    end

    // read data and error caught in the setup cycle, held through access
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (apbSetup) begin
            prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, readValue};
            pslverr_r <= ~reg_hit(paddr);
        end
    end

    // ****************************************************************
    // shared pins
    // ****************************************************************
    // pins 0 and 1 carry servo outputs, pins 2..4 servo inputs
    assign servoIsOut = 5'h03;
    assign servoDrive = {3'h0, headAmpSelectDrive, colorRotaryDrive};

    // one cell per pin; mode bit n releases pin n to the general port
    genvar gi;
    generate
        for (gi = 0; gi < GPIO_WIDTH; gi++) begin : gPin
            servo_gpio_cell uCell (
                .clk_sys(clk_sys),
                .rst(resetAll),
                .gpioMode(pinMode_r[gi]),
                .dirBit(gpioDir_r[gi]),
                .dataBit(gpioData_r[gi]),
                .servoIsOutput(servoIsOut[gi]),
                .servoDrive(servoDrive[gi]),
                .pinIn(servoGpioPinsIn[gi]),
                .pinOut(servoGpioPinsOut[gi]),
                .pinOe(servoGpioPinsOe[gi]),
                .toServo(fromPins[gi]),
                .readBit(gpioRead[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // servo side signals
    // ****************************************************************
    // overlapped drum inputs: phase rides on the tach input
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            drumPhasePulse <= 1'b0;
            drumInputsOverlapped <= 1'b0;
        end else begin
            drumPhasePulse <= pinMode_r[MODE_DRUM_OVERLAP] ? drumTachSignal
                : servoGpioPinsIn[3];
            drumInputsOverlapped <= pinMode_r[MODE_DRUM_OVERLAP];
        end
    end

    // track pulse source: amplifier output or external pin
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            trackPulseToCircuit <= 1'b0;
        end else begin
            trackPulseToCircuit <= ampCtl_r[AMP_SRC_SEL] ? fromPins[4]
                : ampOutputPulse;
        end
    end

    assign preampCompareResult = fromPins[2];
    assign externalTrackPulseInput = fromPins[4];

    // control levels straight from the registers
    assign trackCircuitStop = pinMode_r[MODE_TRACK_STOP];
    assign capstanTachDigital = pinMode_r[MODE_CAP_DIGITAL];
    assign ampFeedbackSwitch = ampCtl_r[AMP_FEEDBACK];
    assign ampGainCode = ampCtl_r[AMP_GAIN_LSB +: 4];

    // gain figure registered to keep the multiplier off the output
    always_ff @(posedge clk_sys) begin
        if (resetAll) begin
            ampGainTenthDb <= GAIN_BASE_TENTH_DB;
        end else begin
            ampGainTenthDb <= gain_tenth_db(ampCtl_r[AMP_GAIN_LSB +: 4]);
        end
    end

    // ****************************************************************
    // monitor outputs
    // ****************************************************************
    // order follows mon_src_t codes
    assign monSources = {drumPhasePulse, drumTachSignal, capstanTachSignal,
        dividedCapstanTach, trackMonitorSignal, capstanReferenceSignal,
        alternateCapstanReference, primaryReferenceSignal};

    servo_monitor_mux uMonA (
        .clk_sys(clk_sys),
        .rst(resetAll),
        .sel(monSel_r[MON_A_LSB +: 3]),
        .sources(monSources),
        .pinSel(monitorPinSelA),
        .monOut(monitorOutA),
        .monOe(monitorOeA)
    );

    servo_monitor_mux uMonB (
        .clk_sys(clk_sys),
        .rst(resetAll),
        .sel(monSel_r[MON_B_LSB +: 3]),
        .sources(monSources),
        .pinSel(monitorPinSelB),
        .monOut(monitorOutB),
        .monOe(monitorOeB)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    chk_ext_track_route: assert property (@(posedge clk_sys) disable iff (resetAll)
        (!pinMode_r[4] && !apbWrite) ##1 ampCtl_r[5] |=>
        trackPulseToCircuit == $past(servoGpioPinsIn[4], 2))
        else $error("external track pulse not routed");
    chk_drum_overlap: assert property (@(posedge clk_sys) disable iff (resetAll)
        pinMode_r[3] |=> drumPhasePulse == $past(drumTachSignal))
        else $error("overlapped drum phase not from tach");
    chk_compare_input: assert property (@(posedge clk_sys) disable iff (resetAll)
        !pinMode_r[2] |=> preampCompareResult == $past(servoGpioPinsIn[2]))
        else $error("compare input not sampled");
    chk_head_amp_drive: assert property (@(posedge clk_sys) disable iff (resetAll)
        !pinMode_r[1] |=> servoGpioPinsOe[1] &&
        servoGpioPinsOut[1] == $past(headAmpSelectDrive))
        else $error("head amp select not driven");
    chk_color_rot_drive: assert property (@(posedge clk_sys) disable iff (resetAll)
        !pinMode_r[0] |=> servoGpioPinsOe[0] &&
        servoGpioPinsOut[0] == $past(colorRotaryDrive))
        else $error("colour rotary not driven");
    chk_gpio_direction: assert property (@(posedge clk_sys) disable iff (resetAll)
        pinMode_r[4] |=> servoGpioPinsOe[4] == $past(gpioDir_r[4]) &&
        (!servoGpioPinsOe[4] || servoGpioPinsOut[4] == $past(gpioData_r[4])))
        else $error("gpio pin ignores direction or latch");
    chk_reset_state: assert property (@(posedge clk_sys)
        resetAll |=> gpioDir_r == 5'h00 && pinMode_r == PIN_MODE_RESET &&
        monSel_r == 6'h00 && ampCtl_r == 6'h00)
        else $error("register reset value wrong");
    chk_data_readback: assert property (@(posedge clk_sys) disable iff (resetAll)
        (apbSetup && !pwrite && reg_hit(paddr) && reg_index(paddr) == IDX_GPIO_DATA)
        |=> prdata[7:0] == {3'h7, ($past(gpioDir_r) & $past(gpioData_r)) |
        (~$past(gpioDir_r) & $past(servoGpioPinsIn))})
        else $error("data readback mixes latch and pin wrongly");
    chk_gain_write: assert property (@(posedge clk_sys) disable iff (resetAll)
        (apbWrite && reg_index(paddr) == IDX_AMP_CTL) |=>
        ampGainCode == $past(pwdata[3:0]) ##1
        ampGainTenthDb == 10'h154 + 10'h019 * {6'h00, $past(pwdata[3:0], 2)})
        else $error("gain code or figure wrong after write");

endmodule

// >>> bench/servo_far_side.sv
// Purpose: far-side model of the five shared servo pins
// Assumes: the design's enable is high while it drives a pin
// Notes: the model lets go of a pin the design drives, so there is no contention
`timescale 1ns/10ps
module servo_far_side (
    input wire logic [4:0] pinOut,
    input wire logic [4:0] pinOe,
    input wire logic [4:0] drive,
    output logic [4:0] level
);
    // **********
    // pin resolution
    // **********
    // an enabled pin shows the design's value, any other shows the far-side level
    assign level = (pinOe & pinOut) | (~pinOe & drive);
endmodule

// >>> bench/servo_port_pin_control_tb_top.sv
// Purpose: self-checking bench for servo port pin control
// Assumes: apb slave answers through pready, pins are resolved by the far-side model
// Notes: expected values are worked out here, never read back from the design
`timescale 1ns/10ps
module servo_port_pin_control_tb_top import servo_port_pkg::*; ();
    // **********
    // signals
    // **********
    logic clk_sys, rst, standby, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] pinOut, pinOe, pinLevel, pinDrv; // pinDrv: far-side pin levels
    logic colorRotaryDrive, headAmpSelectDrive, ampOutputPulse, selA, selB;
    logic compRes, drumPhase, overlap, extPulse, trackPulse, monA, oeA, monB, oeB, fbSw;
    logic tStop, capDig; // mode bits 7 and 5 as seen on the outputs
    logic [3:0] gainCode;
    logic [9:0] gainDb;
    logic [7:0] src; // monitor sources; bit 7 feeds the drum phase pin
    int n_errors, comparisons;
    typedef struct packed {logic [11:0] a; logic [7:0] wd; logic [31:0] rd; logic er;} row_t;
    // write, then read back; the last two rows are unmapped and misaligned
    row_t rows [7] = '{'{12'h000, 8'hbf, 32'hff, 1'b0}, '{12'h000, 8'h00, 32'h40, 1'b0},
        '{12'h004, 8'h1f, 32'hff, 1'b0}, '{12'h00c, 8'h2a, 32'hea, 1'b0},
        '{12'h010, 8'hff, 32'hff, 1'b0}, '{12'h014, 8'h55, 32'h00, 1'b1},
        '{12'h012, 8'h55, 32'h00, 1'b1}};
    logic [7:0] rv [5] = '{8'h40, 8'hff, 8'he0, 8'hc0, 8'hc0}; // values after reset

    servo_port_pin_control u_servo_port_pin_control (.clk_sys(clk_sys), .rst(rst),
        .standby(standby), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .servoGpioPinsIn(pinLevel), .servoGpioPinsOut(pinOut), .servoGpioPinsOe(pinOe),
        .colorRotaryDrive(colorRotaryDrive), .headAmpSelectDrive(headAmpSelectDrive),
        .preampCompareResult(compRes), .drumTachSignal(src[6]), .drumPhasePulse(drumPhase),
        .drumInputsOverlapped(overlap), .externalTrackPulseInput(extPulse),
        .ampOutputPulse(ampOutputPulse), .trackPulseToCircuit(trackPulse),
        .primaryReferenceSignal(src[0]), .alternateCapstanReference(src[1]),
        .capstanReferenceSignal(src[2]), .trackMonitorSignal(src[3]),
        .dividedCapstanTach(src[4]), .capstanTachSignal(src[5]), .monitorPinSelA(selA),
        .monitorPinSelB(selB), .monitorOutA(monA), .monitorOeA(oeA), .monitorOutB(monB),
        .monitorOeB(oeB), .trackCircuitStop(tStop), .capstanTachDigital(capDig),
        .ampFeedbackSwitch(fbSw), .ampGainCode(gainCode), .ampGainTenthDb(gainDb));
    servo_far_side u_servo_far_side (.pinOut(pinOut), .pinOe(pinOe),
        .drive({pinDrv[4], src[7], pinDrv[2:0]}), .level(pinLevel));

    // **********
    // clock, shared tasks
    // **********
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // compare and count; a mismatch is reported at once
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer; the request is held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            output logic [31:0] q, output logic e);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        // no limit here: only the watchdog ends a wait for pready
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // every register read back against its value after reset; the write-only direction reads ff
    task automatic reset_reads();
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 8'h00, rd, err);
            chk(rd, {24'h000000, rv[i]});
        end
        chk({tStop, capDig}, 2'b00);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog: far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        n_errors++;
        complete_run();
    end

    // **********
    // main sequence
    // **********
    initial begin
        {rst, standby, psel, penable, pwrite, paddr, pwdata} = '0;
        {colorRotaryDrive, headAmpSelectDrive, ampOutputPulse, selA, selB, pinDrv, src} = '0;
        rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        reset_reads();
        chk(gainDb, 10'h154);
        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].wd, rd, err);
            chk(err, rows[i].er);
            apb(1'b0, rows[i].a, 8'h00, rd, err);
            chk(rd, rows[i].rd);
        end
        // gain codes, feedback switch and pulse source; pin4 high, amp pulse follows bit 2
        pinDrv <= 5'h10;
        for (int c = 0; c < 16; c++) begin
            ampOutputPulse <= c[2];
            apb(1'b1, 12'h010, {2'b00, c[1], c[0], c[3:0]}, rd, err);
            repeat (2) @(posedge clk_sys);
            chk(gainCode, c[3:0]);
            chk(gainDb, 10'h154 + 10'h019 * c[3:0]);
            chk(fbSw, c[0]);
            chk(trackPulse, c[1] | c[2]);
        end
        // one-hot sources: A must see its source high, B (7 - code) low
        selA <= 1'b1;
        selB <= 1'b1;
        for (int c = 0; c < 8; c++) begin
            src <= 8'h01 << c;
            apb(1'b1, 12'h00c, {2'b00, 3'(7 - c), c[2:0]}, rd, err);
            repeat (3) @(posedge clk_sys);
            chk({oeA, monA, oeB, monB}, 4'he);
        end
        selA <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({oeA, oeB}, 2'b01);
        // servo mode: port settings must not reach the pins
        colorRotaryDrive <= 1'b1;
        pinDrv <= 5'h1e;
        src <= 8'h80;
        apb(1'b1, 12'h004, 8'h1f, rd, err);
        apb(1'b1, 12'h008, 8'h1f, rd, err);
        repeat (2) @(posedge clk_sys);
        chk(pinOe, 5'h03);
        chk(pinOut[1:0], 2'b01);
        chk({compRes, extPulse, drumPhase, overlap}, 4'b1110);
        {colorRotaryDrive, headAmpSelectDrive} <= 2'b01;
        repeat (2) @(posedge clk_sys);
        chk(pinOut[1:0], 2'b10);
        // every pin to the general port, stop and digital tach set; pins 0, 2, 4 outputs
        apb(1'b1, 12'h000, 8'hbf, rd, err);
        apb(1'b1, 12'h004, 8'h15, rd, err);
        apb(1'b1, 12'h008, 8'h04, rd, err);
        repeat (2) @(posedge clk_sys);
        chk(pinOe, 5'h15);
        chk(pinOut & pinOe, 5'h04);
        chk({compRes, extPulse, drumPhase, overlap}, 4'b0001);
        chk({tStop, capDig}, 2'b11);
        apb(1'b0, 12'h008, 8'h00, rd, err);
        chk(rd, 32'hee);
        // standby in mid-run brings back every reset value
        {colorRotaryDrive, headAmpSelectDrive} <= 2'b00;
        pinDrv <= 5'h00;
        src <= 8'h00;
        standby <= 1'b1;
        repeat (2) @(posedge clk_sys);
        standby <= 1'b0;
        reset_reads();
        // all pins to the general port: the reset direction leaves every pin an input
        apb(1'b1, 12'h000, 8'h1f, rd, err);
        repeat (2) @(posedge clk_sys);
        chk(pinOe, 5'h00);
        complete_run();
    end
endmodule
